// ==== logic/ivp_core.sv ====
// Interrupt vector priority map: reset origin arbitration, cause flags and
// maskable request resolution toward the processor core, with AHB-Lite registers.
// Assumes hresetn is the power-on reset; reset pin and low-voltage level arrive asynchronously.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module ivp_core
  import ivp_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Reset origins
  input  wire logic               ext_reset_n,
  input  wire logic               low_voltage_reset,
  input  wire logic               clock_monitor_fail,
  input  wire logic               watchdog_timeout,
  // Maskable sources, level requests
  input  wire logic [NUM_SRC-1:0] src_req,
  // Toward the core
  output logic                    reset_req,
  output logic [15:0]             reset_vector,
  output logic [1:0]              reset_priority,
  output logic                    irq_req,
  output logic [15:0]             irq_vector,
  output logic                    irq_out
);

  // Registers
  logic [7:0]         ctrl_r;
  logic [7:0]         top_priority_select_r;
  logic [NUM_SRC-1:0] local_en_r;
  logic [1:0]         pulse_acc_control_r;
  logic [FLG_W-1:0]   flags_r;
  logic [FLG_W-1:0]   flags_nxt;
  logic [FLG_W-1:0]   mask_r;
  logic               reset_req_r;
  logic [15:0]        reset_vector_r;
  logic [1:0]         reset_priority_r;
  logic               irq_req_r;
  logic [15:0]        irq_vector_r;
  logic [31:0]        hrdata_r;

  // AHB data phase state
  logic               dp_write_r;
  logic [7:0]         dp_addr_r;

  // Synchronisers for the asynchronous reset origins
  logic [1:0]         pin_sync_r;
  logic [1:0]         lowv_sync_r;

  // Field views
  wire logic          condition_code_register_i = ctrl_r[CTRL_IBIT];
  wire logic          clock_monitor_enable = ctrl_r[CTRL_MON_EN];
  wire logic          forced_clock_monitor_enable = ctrl_r[CTRL_MON_FRC];
  wire logic [WD_W-1:0] watchdog_control = ctrl_r[CTRL_WD_LSB +: WD_W];
  wire logic          pulse_acc_overflow_ie = pulse_acc_control_r[PACC_OVF_IE];
  wire logic          pulse_acc_edge_ie = pulse_acc_control_r[PACC_EDGE_IE];

  // Bus decode
  wire logic          addr_phase = hsel && hready && htrans[1];
  wire logic          wr_ctrl   = dp_write_r && (dp_addr_r == ADDR_CTRL);
  wire logic          wr_top    = dp_write_r && (dp_addr_r == ADDR_TOPPRI);
  wire logic          wr_locen  = dp_write_r && (dp_addr_r == ADDR_LOCEN);
  wire logic          wr_pacc   = dp_write_r && (dp_addr_r == ADDR_PACC);
  wire logic          wr_flags  = dp_write_r && (dp_addr_r == ADDR_FLAGS);
  wire logic          wr_mask   = dp_write_r && (dp_addr_r == ADDR_MASK);

  // Reset origins after synchronisation; only the second stage is read
  wire logic          pin_active  = !pin_sync_r[1];
  wire logic          lowv_active = lowv_sync_r[1];
  wire logic          common_act  = pin_active || lowv_active; // [R3] [R4]
  wire logic          cmon_act    = clock_monitor_fail &&
                                    (clock_monitor_enable || forced_clock_monitor_enable); // [R5]
  wire logic          wdog_act    = watchdog_timeout && (watchdog_control != '0);
  wire logic          any_reset   = common_act || cmon_act || wdog_act; // [R3]

  // Reset vector selection in fixed priority order
  wire logic [15:0]   rst_vec_sel = common_act ? VEC_COMMON :
                                    cmon_act   ? VEC_CMON   : VEC_WDOG; // [R9]
  wire logic [1:0]    rst_pri_sel = common_act ? PRI_COMMON :
                                    cmon_act   ? PRI_CMON   : PRI_WDOG; // [R9]

  // Effective local enables: pulse accumulator slots follow their own control bits
  logic [NUM_SRC-1:0] en_eff;
  always_comb begin
    en_eff = local_en_r;
    en_eff[IDX_PA_OVF]  = pulse_acc_overflow_ie; // [R6]
    en_eff[IDX_PA_EDGE] = pulse_acc_edge_ie;     // [R7]
  end

  wire logic [NUM_SRC-1:0] masked = src_req & en_eff; // [R2]
  wire logic               top_ok = vec_is_src(top_priority_select_r);
  wire logic [IDX_W-1:0]   top_idx = vec_to_idx(top_priority_select_r);
  logic                    pick_found;
  logic                    pick_promoted;
  logic [IDX_W-1:0]        pick_idx;

  ivp_prio_pick u_pick (
    .req      (masked),
    .top_idx  (top_idx),
    .top_ok   (top_ok),
    .found    (pick_found),
    .promoted (pick_promoted),
    .idx      (pick_idx)
  );

  // Cause flags: a new cause wins over a write-one-to-clear in the same cycle
  wire logic [FLG_W-1:0] flag_set = {wdog_act, cmon_act, lowv_active, pin_active, 1'b0};
  wire logic [FLG_W-1:0] flag_clr = wr_flags ? hwdata[FLG_W-1:0] : '0;
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set; // [R8]

  // Read mux, sampled at the address phase
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr[7:0])
      ADDR_CTRL:   rd_mux = {24'h0, ctrl_r};
      ADDR_TOPPRI: rd_mux = {24'h0, top_priority_select_r};
      ADDR_LOCEN:  rd_mux = local_en_r;
      ADDR_PACC:   rd_mux = {30'h0, pulse_acc_control_r};
      ADDR_FLAGS:  rd_mux = {27'h0, flags_r};
      ADDR_MASK:   rd_mux = {27'h0, mask_r};
      ADDR_VEC:    rd_mux = {irq_req_r, 15'h0, irq_vector_r};
      default:     rd_mux = 32'h0;
    endcase
  end

  // Synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sync_r <= 2'h3;
      lowv_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], ext_reset_n};
      lowv_sync_r <= {lowv_sync_r[0], low_voltage_reset};
    end
  end

  // Bus address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_r <= 1'b0;
      dp_addr_r  <= 8'h00;
      hrdata_r   <= 32'h0;
    end else begin
      dp_write_r <= addr_phase && hwrite;
      dp_addr_r  <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r                <= CTRL_RESET;
      top_priority_select_r <= TOPPRI_RESET;
      local_en_r            <= '0;
      pulse_acc_control_r   <= 2'h0;
      mask_r                <= '0;
    end else begin
      if (wr_ctrl)  ctrl_r                <= hwdata[7:0];
      if (wr_top)   top_priority_select_r <= hwdata[7:0]; // [R10]
      if (wr_locen) local_en_r            <= hwdata;
      if (wr_pacc)  pulse_acc_control_r   <= hwdata[1:0];
      if (wr_mask)  mask_r                <= hwdata[FLG_W-1:0];
    end
  end

  // Cause flags; power-on is marked by the reset value itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= FLAGS_RESET; // [R8]
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Reset request to the core, held while any origin stays active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_req_r      <= 1'b0;
      reset_vector_r   <= VEC_COMMON;
      reset_priority_r <= PRI_COMMON;
    end else begin
      reset_req_r <= any_reset; // [R3]
      if (any_reset) begin
        reset_vector_r   <= rst_vec_sel; // [R4] [R5]
        reset_priority_r <= rst_pri_sel; // [R9]
      end
    end
  end

  // Maskable request: vector tracks the winner even while masked by the core bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req_r    <= 1'b0;
      irq_vector_r <= {VEC_PAGE, VEC_TOP};
    end else begin
      irq_req_r <= pick_found && !condition_code_register_i; // [R2]
      if (pick_found) begin
        irq_vector_r <= idx_to_vec(pick_idx); // [R1] [R6] [R7]
      end
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = hrdata_r;
  assign reset_req      = reset_req_r;
  assign reset_vector   = reset_vector_r;
  assign reset_priority = reset_priority_r;
  assign irq_req        = irq_req_r;
  assign irq_vector     = irq_vector_r;
  // Level interrupt while any unmasked cause flag stands
  assign irq_out        = |(flags_r & mask_r);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_common_seen;
    common_act;
  endsequence

  sequence s_common_vector;
    reset_req && (reset_vector == VEC_COMMON) && (reset_priority == PRI_COMMON);
  endsequence

  chk_core_mask_gate: assert property ( // [R2]
    condition_code_register_i |=> !irq_req)
    else $error("request passed while core mask set");

  chk_local_enable: assert property ( // [R2]
    irq_req |-> $past(|(src_req & en_eff)))
    else $error("request without an enabled source");

  chk_default_order: assert property ( // [R1]
    (masked[0] && !pick_promoted && !condition_code_register_i) |=>
      (irq_req && irq_vector == 16'hfff2))
    else $error("highest vector did not win");

  chk_top_promote: assert property ( // [R10]
    (pick_promoted && !condition_code_register_i) |=>
      (irq_req && irq_vector == {VEC_PAGE, $past(top_priority_select_r)}))
    else $error("promoted source did not win");

  chk_pa_overflow: assert property ( // [R6]
    (masked == (32'h1 << IDX_PA_OVF) && !condition_code_register_i) |=>
      (irq_req && irq_vector == 16'hffdc))
    else $error("overflow vector wrong");

  chk_pa_edge: assert property ( // [R7]
    (masked == (32'h1 << IDX_PA_EDGE) && !condition_code_register_i) |=>
      (irq_req && irq_vector == 16'hffda))
    else $error("edge vector wrong");

  chk_common_vec: assert property ( // [R4]
    s_common_seen |=> s_common_vector)
    else $error("common reset vector wrong");

  chk_cmon_vec: assert property ( // [R5]
    (cmon_act && !common_act) |=>
      (reset_req && reset_vector == VEC_CMON && reset_priority == PRI_CMON))
    else $error("clock monitor reset vector wrong");

  chk_wdog_prio: assert property ( // [R9]
    (wdog_act && !cmon_act && !common_act) |=>
      (reset_vector == VEC_WDOG && reset_priority == PRI_WDOG))
    else $error("watchdog reset priority wrong");

  chk_pin_reset: assert property ( // [R3]
    $fell(ext_reset_n) |-> ##[3:4] reset_req)
    else $error("pin reset not raised");

  chk_cause_flag: assert property ( // [R8]
    (pin_active || lowv_active) |=>
      ((flags_r[FLG_PIN] || !$past(pin_active)) &&
       (flags_r[FLG_LOWV] || !$past(lowv_active))))
    else $error("reset cause not recorded");

  // Refused origins, release and the low-voltage raise: a cut origin must not leave the core in reset
  sequence s_reset_dropped;
    !reset_req;
  endsequence

  chk_cmon_refused: assert property ( // [R5]
    (clock_monitor_fail && !clock_monitor_enable && !forced_clock_monitor_enable &&
     !common_act && !wdog_act) |=> s_reset_dropped)
    else $error("clock monitor reset passed while disabled");

  chk_wdog_refused: assert property ( // [R3]
    (watchdog_timeout && (watchdog_control == '0) && !common_act && !cmon_act) |=>
      s_reset_dropped)
    else $error("watchdog reset passed with rate zero");

  chk_reset_release: assert property ( // [R3]
    !any_reset |=> s_reset_dropped)
    else $error("reset request outlived its origin");

  chk_lowv_reset: assert property ( // [R3]
    $rose(low_voltage_reset) |-> ##[3:4] reset_req)
    else $error("low-voltage reset not raised");

  // Vectors hold between events so the core never fetches a stray address
  chk_rst_vec_hold: assert property ( // [R9]
    !any_reset |=> ($stable(reset_vector) && $stable(reset_priority)))
    else $error("reset vector moved without an origin");

  chk_irq_vec_hold: assert property ( // [R1]
    !pick_found |=> $stable(irq_vector))
    else $error("interrupt vector moved with nothing pending");

  // Pulse accumulator slots obey their own enables, not the general enable word
  chk_pa_ovf_gate: assert property ( // [R6]
    ((src_req == (32'h1 << IDX_PA_OVF)) && !pulse_acc_overflow_ie) |=> !irq_req)
    else $error("overflow request passed while disabled");

  chk_pa_edge_gate: assert property ( // [R7]
    ((src_req == (32'h1 << IDX_PA_EDGE)) && !pulse_acc_edge_ie) |=> !irq_req)
    else $error("edge request passed while disabled");

  // Cause flags: an origin is recorded, and a same-cycle clear cannot hide it
  chk_cmon_flag: assert property ( // [R8]
    cmon_act |=> flags_r[FLG_CMON])
    else $error("clock monitor cause not recorded");

  chk_wdog_flag: assert property ( // [R8]
    wdog_act |=> flags_r[FLG_WDOG])
    else $error("watchdog cause not recorded");

  chk_set_wins: assert property ( // [R8]
    (wr_flags && ((flag_set & hwdata[FLG_W-1:0]) != '0)) |=>
      ((flags_r & $past(flag_set)) == $past(flag_set)))
    else $error("flag clear beat a new cause");

endmodule

// ==== logic/ivp_pkg.sv ====
// Constants, register map and helpers for the interrupt vector priority map.
// Assumes a single 40 MHz bus clock and an AHB-Lite master reaching the registers.
// Operation
// R1: Among simultaneous pending maskable sources the one at the highest vector wins.
// R2: A maskable request reaches the core only when its local enable and the core mask allow it.
// R3: A system reset is generated from the reset pin, the clock/reset generator and the low-voltage detector.
// R4: Pin, power-on and low-voltage resets all fetch the vector 0xFFFE with no local enable.
// R5: A clock monitor failure fetches 0xFFFC, enabled by the monitor or forced monitor bit.
// R6: Pulse accumulator overflow maps to 0xFFDC, gated by its enable, elevated by value 0xDC.
// R7: Pulse accumulator edge maps to 0xFFDA, gated by its enable, elevated by value 0xDA.
// R8: Flags record which origin caused a reset that shares the common vector.
// R9: Common resets have priority 1, clock monitor reset 2 and watchdog reset 3.
// R10: The source named by the top priority select beats all other maskable sources.
package ivp_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TOPPRI = 8'h04;
  localparam logic [7:0] ADDR_LOCEN  = 8'h08;
  localparam logic [7:0] ADDR_PACC   = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS  = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_VEC    = 8'h18;

  // Control register fields (condition code mask, clock monitor, watchdog rate)
  localparam int CTRL_IBIT    = 0;
  localparam int CTRL_MON_EN  = 1;
  localparam int CTRL_MON_FRC = 2;
  localparam int CTRL_WD_LSB  = 4;
  localparam int WD_W         = 3;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // Pulse accumulator control fields
  localparam int PACC_OVF_IE  = 0;
  localparam int PACC_EDGE_IE = 1;

  // Reset cause flags, same layout in the mask register
  localparam int FLG_POR  = 0;
  localparam int FLG_PIN  = 1;
  localparam int FLG_LOWV = 2;
  localparam int FLG_CMON = 3;
  localparam int FLG_WDOG = 4;
  localparam int FLG_W    = 5;
  localparam logic [FLG_W-1:0] FLAGS_RESET = 5'h01;

  // Maskable sources: index 0 is vector 0xF2, each next index two bytes lower
  localparam int NUM_SRC = 32;
  localparam int IDX_W   = 5;
  localparam logic [7:0] VEC_TOP     = 8'hf2;
  localparam logic [7:0] VEC_PAGE    = 8'hff;
  localparam logic [7:0] TOPPRI_RESET = 8'hf2;
  localparam logic [IDX_W-1:0] IDX_PA_OVF  = 5'h0b;
  localparam logic [IDX_W-1:0] IDX_PA_EDGE = 5'h0c;

  // Reset vectors and their priorities
  localparam logic [15:0] VEC_COMMON = 16'hfffe;
  localparam logic [15:0] VEC_CMON   = 16'hfffc;
  localparam logic [15:0] VEC_WDOG   = 16'hfffa;
  localparam logic [1:0]  PRI_COMMON = 2'h1;
  localparam logic [1:0]  PRI_CMON   = 2'h2;
  localparam logic [1:0]  PRI_WDOG   = 2'h3;

  // Vector low byte to source index
  function automatic logic [IDX_W-1:0] vec_to_idx(input logic [7:0] v);
    logic [7:0] d;
    d = VEC_TOP - v;
    return d[IDX_W:1];
  endfunction

  // True when the low byte names an existing maskable source
  function automatic logic vec_is_src(input logic [7:0] v);
    logic [7:0] d;
    d = VEC_TOP - v;
    return (v <= VEC_TOP) && !v[0] && (d[7:1] < 7'(NUM_SRC));
  endfunction

  // Source index to full vector address
  function automatic logic [15:0] idx_to_vec(input logic [IDX_W-1:0] i);
    logic [7:0] lo;
    lo = VEC_TOP - {2'h0, i, 1'b0};
    return {VEC_PAGE, lo};
  endfunction

endpackage

// ==== logic/ivp_prio_pick.sv ====
// Fixed-order picker for the maskable sources with one promoted slot.
// Assumes requests are already gated; purely combinational.
`timescale 1ns/1ps
module ivp_prio_pick
  import ivp_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] req,
  input  wire logic [IDX_W-1:0]   top_idx,
  input  wire logic               top_ok,
  output logic                    found,
  output logic                    promoted,
  output logic [IDX_W-1:0]        idx
);

  logic [IDX_W-1:0] low_idx;
  wire              top_hit = top_ok && req[top_idx];

  // Walk downward so the lowest index, the highest vector, is kept last
  always_comb begin
    low_idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        low_idx = IDX_W'(i); // [R1]
      end
    end
  end

  assign found    = |req;
  assign promoted = top_hit;
  assign idx      = top_hit ? top_idx : low_idx; // [R10]

endmodule

// ==== verification/ivp_core_model.sv ====
// Behavioural processor core that fetches a vector when a request rises or its vector changes.
// Assumes the requests and vectors are registered outputs in the hclk domain.
`timescale 1ns/1ps
module ivp_core_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        reset_req,
  input  wire logic [15:0] reset_vector,
  input  wire logic [1:0]  reset_priority,
  output logic             irq_fetch,
  output logic [15:0]      irq_fetch_vec,
  output logic             rst_fetch,
  output logic [17:0]      rst_fetch_info
);
  logic        irq_seen_r;
  logic        rst_seen_r;
  logic [15:0] irq_last_r;
  logic [15:0] rst_last_r;

  // A fetch is a fresh request or a new winner while one stands; a steady
  // request is fetched once only, so the bench sees each decision once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_fetch      <= 1'b0;
      irq_fetch_vec  <= 16'h0;
      rst_fetch      <= 1'b0;
      rst_fetch_info <= 18'h0;
      irq_seen_r     <= 1'b0;
      rst_seen_r     <= 1'b0;
      irq_last_r     <= 16'h0;
      rst_last_r     <= 16'h0;
    end else begin
      irq_fetch      <= irq_req && (!irq_seen_r || irq_vector != irq_last_r);
      irq_fetch_vec  <= irq_vector;
      rst_fetch      <= reset_req && (!rst_seen_r || reset_vector != rst_last_r);
      rst_fetch_info <= {reset_vector, reset_priority};
      irq_seen_r     <= irq_req;
      rst_seen_r     <= reset_req;
      irq_last_r     <= irq_vector;
      rst_last_r     <= reset_vector;
    end
  end
endmodule

// ==== verification/interrupt_vector_priority_map_tb.sv ====
// Self-checking bench: AHB-Lite register access, source arbitration, resets.
// Assumes the zero-wait slave of ivp_core and the core model beside it.
`timescale 1ns/1ps
module interrupt_vector_priority_map_tb;
  import ivp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, src_req;
  logic [1:0]  htrans, reset_priority;
  logic [2:0]  hsize;
  logic        ext_reset_n, low_voltage_reset, clock_monitor_fail, watchdog_timeout;
  logic        reset_req, irq_req, irq_out, irq_fetch, rst_fetch, rd_pend;
  logic [15:0] reset_vector, irq_vector, irq_fetch_vec;
  logic [17:0] rst_fetch_info;
  logic [31:0] exp_rd [$];
  logic [15:0] exp_irq [$];
  logic [17:0] exp_rst [$];
  int          bad_count, n_tests, i, k, w;
  logic [31:0] r;
  logic [7:0]  t;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rx [8] = '{32'h1, 32'hf2, 32'h0, 32'h0, 32'h1, 32'h0, 32'hfff2, 32'h0};
  logic [7:0]  rc [7] = '{8'h01, 8'h03, 8'h05, 8'h01, 8'h01, 8'h11, 8'h01};
  logic [3:0]  ro [7] = '{4'h4, 4'h4, 4'h4, 4'h1, 4'h2, 4'h8, 4'h8};
  logic [31:0] rf [7] = '{32'h0, 32'h8, 32'h8, 32'h2, 32'h4, 32'h10, 32'h0};
  logic [17:0] rv [7] = '{18'h0, {16'hfffc, 2'h2}, {16'hfffc, 2'h2}, {16'hfffe, 2'h1},
                          {16'hfffe, 2'h1}, {16'hfffa, 2'h3}, 18'h0};

  ivp_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset_n(ext_reset_n),
    .low_voltage_reset(low_voltage_reset), .clock_monitor_fail(clock_monitor_fail),
    .watchdog_timeout(watchdog_timeout), .src_req(src_req), .reset_req(reset_req),
    .reset_vector(reset_vector), .reset_priority(reset_priority), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_out(irq_out));

  ivp_core_model core (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
    .irq_vector(irq_vector), .reset_req(reset_req), .reset_vector(reset_vector),
    .reset_priority(reset_priority), .irq_fetch(irq_fetch), .irq_fetch_vec(irq_fetch_vec),
    .rst_fetch(rst_fetch), .rst_fetch_info(rst_fetch_info));

  // Single slave: its ready output is the bus ready
  assign hready = hreadyout;

  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    check(32'(exp_rd.size() + exp_irq.size() + exp_rst.size()), 32'h0);
    $display("compares=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Wait for hready high at a rising edge; a stuck slave is left to the hang guard
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic origin(input logic [3:0] o);
    ext_reset_n        <= !o[0];
    low_voltage_reset  <= o[1];
    clock_monitor_fail <= o[2];
    watchdog_timeout   <= o[3];
  endtask

  // Monitor: every read data phase and every core fetch takes the oldest note
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      check(hrdata, exp_rd.size() ? exp_rd.pop_front() : 'x);
      check({31'h0, hresp}, 32'h0);
    end
    if (irq_fetch === 1'b1)
      check({16'h0, irq_fetch_vec}, {16'h0, exp_irq.size() ? exp_irq.pop_front() : 'x});
    if (rst_fetch === 1'b1)
      check({14'h0, rst_fetch_info}, {14'h0, exp_rst.size() ? exp_rst.pop_front() : 'x});
    rd_pend <= hsel && htrans[1] && !hwrite && hready;
  end

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    stop_test();
  end

  initial begin
    {hresetn, hwrite, low_voltage_reset, clock_monitor_fail} = '0;
    {hsel, ext_reset_n} = 2'h3;
    {haddr, hwdata, src_req, htrans, watchdog_timeout} = '0;
    hsize = 3'h2;
    void'($urandom(2332));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, unmapped and read-only places left untouched by writes
    wr(8'h1c, 32'hffff_ffff);
    wr(ADDR_VEC, 32'h0);
    for (k = 0; k < 8; k++)
      rd(ra[k], rx[k]);
    $display("test register_map done");
    // Random sources: held off by the core mask, then released
    wr(ADDR_LOCEN, 32'hffff_ffff);
    r = $urandom;
    r[31] = 1'b1;
    for (i = 31; i >= 0; i--) begin
      if (r[i] && i != 11 && i != 12)
        w = i;
    end
    src_req <= r;
    idle(4);
    exp_irq.push_back(16'hfff2 - 16'(2 * w));
    wr(ADDR_CTRL, 32'h0);
    idle(3);
    rd(ADDR_VEC, {1'b1, 15'h0, 16'hfff2 - 16'(2 * w)});
    wr(ADDR_LOCEN, 32'h0);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_LOCEN, 32'hffff_ffff);
    src_req <= 32'h0;
    wr(ADDR_CTRL, 32'h0);
    $display("test masking done");
    // Sources added from the lowest vector up, each new one must win
    wr(ADDR_PACC, 32'h3);
    for (i = 31; i >= 0; i--) begin
      exp_irq.push_back(16'hfff2 - 16'(2 * i));
      src_req[i] <= 1'b1;
      idle(3);
    end
    $display("test default_order done");
    // Promotion by the top priority select
    t = 8'hf2 - 8'(2 * (13 + $urandom % 18));
    exp_irq.push_back(16'hffdc);
    wr(ADDR_TOPPRI, 32'hdc);
    exp_irq.push_back(16'hffda);
    wr(ADDR_TOPPRI, 32'hda);
    exp_irq.push_back({8'hff, t});
    wr(ADDR_TOPPRI, {24'h0, t});
    exp_irq.push_back(16'hfff2);
    wr(ADDR_TOPPRI, 32'h1);
    wr(ADDR_PACC, 32'h0);
    wr(ADDR_TOPPRI, 32'hdc);
    src_req <= 32'h1000;
    idle(3);
    exp_irq.push_back(16'hffda);
    wr(ADDR_PACC, 32'h2);
    idle(3);
    exp_irq.push_back(16'hffdc);
    src_req <= 32'h0800;
    wr(ADDR_PACC, 32'h1);
    idle(3);
    src_req <= 32'h0;
    idle(3);
    $display("test promotion done");
    // Each reset origin: vector, priority, cause flag and status interrupt
    for (k = 0; k < 7; k++) begin
      wr(ADDR_FLAGS, 32'h1f);
      wr(ADDR_MASK, k[0] ? 32'h1f : 32'h0);
      wr(ADDR_CTRL, {24'h0, rc[k]});
      if (rf[k] != 0)
        exp_rst.push_back(rv[k]);
      origin(ro[k]);
      idle(6);
      origin(4'h0);
      idle(4);
      rd(ADDR_FLAGS, rf[k]);
      check({31'h0, irq_out}, {31'h0, k[0] && rf[k] != 0});
    end
    wr(ADDR_FLAGS, 32'h1f);
    rd(ADDR_FLAGS, 32'h0);
    check({31'h0, irq_out}, 32'h0);
    // Overlapping origins resolve by reset priority
    wr(ADDR_CTRL, 32'h13);
    exp_rst.push_back({16'hfffe, 2'h1});
    exp_rst.push_back({16'hfffc, 2'h2});
    exp_rst.push_back({16'hfffa, 2'h3});
    origin(4'h1);
    idle(5);
    origin(4'hd);
    wr(ADDR_FLAGS, 32'h1f);
    rd(ADDR_FLAGS, 32'h1a);
    origin(4'hc);
    idle(5);
    origin(4'h8);
    idle(4);
    origin(4'h0);
    idle(6);
    $display("test reset_origins done");
    stop_test();
  end
endmodule
